// ---- shared/aof_pkg.sv ----
// aof_pkg: constants for the adc offset filter and saturation back end
package aof_pkg;
	localparam int			ADDR_W		= 8;
	localparam int			DATA_W		= 8;
	localparam int			IN_W		= 28;
	localparam int			OUT_W		= 24;
	localparam int			SLOT_W		= 72;
	localparam int			NUM_GPO		= 7;
	localparam int			HPF_SHIFT	= 12;
	localparam int			CNT_W		= 13;
	// register offsets
	localparam logic [7:0]	REG_FMODE	= 8'h03;
	localparam logic [7:0]	REG_MISC	= 8'h05;
	localparam logic [7:0]	REG_CLK		= 8'h06;
	localparam logic [7:0]	REG_GAIN_L	= 8'h1C;
	localparam logic [7:0]	REG_GAIN_R	= 8'h1D;
	localparam logic [7:0]	REG_ISTAT	= 8'h20;
	localparam logic [7:0]	REG_IMASK	= 8'h21;
	localparam logic [7:0]	REG_GPO_LO	= 8'h29;
	localparam logic [7:0]	REG_GPO_HI	= 8'h2F;
	// field positions
	localparam int			MISC_HOLD	= 0;
	localparam int			MISC_HPF	= 1;
	localparam int			MISC_ONE	= 2;
	localparam int			CLK_SEL		= 0;
	localparam int			ST_OVF		= 0;
	localparam int			ST_RATE		= 1;
	// reset values
	localparam logic [7:0]	FMODE_RST	= 8'h00;
	localparam logic [7:0]	MISC_RST	= 8'h02;
	localparam logic [7:0]	ZERO_RST	= 8'h00;
	// speed field codes and oversampling ratios
	localparam logic [1:0]	MODE_DOUBLE	= 2'h1;
	localparam logic [1:0]	MODE_QUAD	= 2'h2;
	localparam logic [7:0]	OSR_SINGLE	= 8'h80;
	localparam logic [7:0]	OSR_DOUBLE	= 8'h40;
	localparam logic [7:0]	OSR_QUAD	= 8'h20;
	// highest frame rates and least frame periods in mclk cycles
	localparam int			CLK_NS		= 5;
	localparam int			KHZ_SINGLE	= 50;
	localparam int			KHZ_DOUBLE	= 100;
	localparam int			KHZ_QUAD	= 192;
	localparam logic [12:0]	MINP_SINGLE	= 13'((1000000 + KHZ_SINGLE * CLK_NS - 1) / (KHZ_SINGLE * CLK_NS));
	localparam logic [12:0]	MINP_DOUBLE	= 13'((1000000 + KHZ_DOUBLE * CLK_NS - 1) / (KHZ_DOUBLE * CLK_NS));
	localparam logic [12:0]	MINP_QUAD	= 13'((1000000 + KHZ_QUAD * CLK_NS - 1) / (KHZ_QUAD * CLK_NS));
	// clamp values and output pin functions
	localparam logic [23:0]	POS_FS		= 24'h7F_FFFF;
	localparam logic [23:0]	NEG_FS		= 24'h80_0000;
	localparam logic [1:0]	GPO_FN_HIGH	= 2'h1;
	localparam logic [1:0]	GPO_FN_OVF	= 2'h2;
	typedef enum logic [2:0] {
		SPD_SINGLE	= 3'b001,
		SPD_DOUBLE	= 3'b010,
		SPD_QUAD	= 3'b100
	} aof_speed_type;
endpackage : aof_pkg

// ---- hdl/aof_filter.sv ----
// aof_filter: adc back end with offset removal, clamping, flags and one-line serial output
module aof_filter (
	input	wire logic						mclk,
	input	wire logic						rst,
	input	wire logic						ce,
	input	wire logic [aof_pkg::ADDR_W-1:0]	reg_addr,
	input	wire logic [aof_pkg::DATA_W-1:0]	reg_wdata,
	input	wire logic						reg_wr,
	input	wire logic						reg_rd,
	input	wire logic						dec_valid,
	input	wire logic						dec_right,
	input	wire logic [aof_pkg::IN_W-1:0]	dec_data,
	input	wire logic [aof_pkg::OUT_W-1:0]	ext1_left,
	input	wire logic [aof_pkg::OUT_W-1:0]	ext1_right,
	input	wire logic [aof_pkg::OUT_W-1:0]	ext2_left,
	input	wire logic [aof_pkg::OUT_W-1:0]	ext2_right,
	input	wire logic						adc_frame_clock,
	input	wire logic						adc_bit_clock,
	output	logic [aof_pkg::DATA_W-1:0]		reg_rdata_q,
	output	logic							adc_sdout_q,
	output	logic [7:0]						osr_ratio_q,
	output	logic							sys_clk_sel_q,
	output	logic [aof_pkg::NUM_GPO-1:0]	general_output_pin_q,
	output	logic							irq_q
);
	import aof_pkg::*;

	function automatic aof_speed_type speed_of(input logic [1:0] code);
		case (code)
			MODE_DOUBLE: return SPD_DOUBLE;
			MODE_QUAD: return SPD_QUAD;
			default: return SPD_SINGLE;
		endcase
	endfunction : speed_of

	function automatic logic gpo_level(input logic [1:0] fn, input logic ovf);
		case (fn)
			GPO_FN_HIGH: return 1'b1;
			GPO_FN_OVF: return ovf;
			default: return 1'b0;
		endcase
	endfunction : gpo_level

	logic [7:0]						fmode_q;
	logic [7:0]						misc_q;
	logic [7:0]						clksel_q;
	logic [7:0]						gain_l_q;
	logic [7:0]						gain_r_q;
	logic [7:0]						status_q;
	logic [7:0]						mask_q;
	logic [7:0]						gpo_reg_q [NUM_GPO];
	aof_speed_type					spd_q;
	logic signed [IN_W-1:0]			est_l_q;
	logic signed [IN_W-1:0]			est_r_q;
	logic [OUT_W-1:0]				word_l_q;
	logic [OUT_W-1:0]				word_r_q;
	logic							frm_s1_q;
	logic							frm_s2_q;
	logic							frm_s3_q;
	logic							bclk_s1_q;
	logic							bclk_s2_q;
	logic							bclk_s3_q;
	logic [SLOT_W-1:0]				shift_q;
	logic [CNT_W-1:0]				per_cnt_q;
	logic							primed_q;

	// register port decode
	// control port
	wire take_wr	= ce & reg_wr;
	wire wr_fmode	= take_wr && reg_addr == REG_FMODE;
	wire wr_misc	= take_wr && reg_addr == REG_MISC;
	wire wr_clk		= take_wr && reg_addr == REG_CLK;
	wire wr_gain_l	= take_wr && reg_addr == REG_GAIN_L;
	wire wr_gain_r	= take_wr && reg_addr == REG_GAIN_R;
	wire wr_mask	= take_wr && reg_addr == REG_IMASK;
	wire gpo_hit	= reg_addr >= REG_GPO_LO && reg_addr <= REG_GPO_HI;
	wire [2:0] gpo_idx = 3'(reg_addr - REG_GPO_LO);
	wire rd_istat	= ce && reg_rd && reg_addr == REG_ISTAT;

	wire [7:0] rd_mux =
		(reg_addr == REG_FMODE)	? fmode_q :
		(reg_addr == REG_MISC)	? misc_q :
		(reg_addr == REG_CLK)	? clksel_q :
		(reg_addr == REG_GAIN_L)	? gain_l_q :
		(reg_addr == REG_GAIN_R)	? gain_r_q :
		(reg_addr == REG_ISTAT)	? status_q :
		(reg_addr == REG_IMASK)	? mask_q :
		gpo_hit					? gpo_reg_q[gpo_idx] : 8'h00;

	wire hold		= misc_q[MISC_HOLD];
	wire hpf_en		= misc_q[MISC_HPF];
	wire one_line	= misc_q[MISC_ONE];

	// sample path: offset removal, gain, clamp
	wire take		= ce & dec_valid;
	wire signed [IN_W-1:0] est_sel = dec_right ? est_r_q : est_l_q;
	wire signed [IN_W:0] in_ext = {dec_data[IN_W-1], dec_data};
	wire signed [IN_W:0] est_ext = {est_sel[IN_W-1], est_sel};
	wire signed [IN_W:0] resid = in_ext - est_ext;
	wire signed [IN_W:0] step = resid >>> HPF_SHIFT;
	wire [IN_W:0] est_sum = est_ext + step;
	wire signed [IN_W-1:0] est_new = est_sum[IN_W-1:0];
	// hold keeps subtracting even with the filter off
	wire subtract	= hpf_en | hold;
	// estimate moves only while filtering and not held
	wire track		= take & hpf_en & ~hold;
	wire signed [IN_W:0] cleaned = subtract ? resid : in_ext;
	wire [1:0] gain	= dec_right ? gain_r_q[1:0] : gain_l_q[1:0];
	wire signed [IN_W+3:0] gained = $signed({{3{cleaned[IN_W]}}, cleaned}) <<< gain;
	// range judged on the final gained word
	wire [IN_W+4-OUT_W:0] top = gained[IN_W+3:OUT_W-1];
	wire clip		= ~(&top | ~|top);
	wire neg		= gained[IN_W+3];
	wire [OUT_W-1:0] word_new = !clip ? gained[OUT_W-1:0] : (neg ? NEG_FS : POS_FS);
	wire ovf_evt	= take & clip;

	// link side edges from synchronised clocks
	wire frm_edge	= frm_s2_q ^ frm_s3_q;
	wire frm_rise	= frm_s2_q & ~frm_s3_q;
	wire bclk_fall	= ~bclk_s2_q & bclk_s3_q;
	// frame clock high carries the left slots
	wire [OUT_W-1:0] side_word = frm_s2_q ? word_l_q : word_r_q;
	wire [OUT_W-1:0] side_ext1 = frm_s2_q ? ext1_left : ext1_right;
	wire [OUT_W-1:0] side_ext2 = frm_s2_q ? ext2_left : ext2_right;
	// one-line mode appends the two external pairs
	wire [SLOT_W-1:0] slot_load = one_line ? {side_word, side_ext1, side_ext2}
		: {side_word, {(SLOT_W-OUT_W){1'b0}}};
	wire [SLOT_W-1:0] shift_d = frm_edge ? slot_load
		: bclk_fall ? {shift_q[SLOT_W-2:0], 1'b0} : shift_q;

	// least frame period for the chosen speed
	wire [CNT_W-1:0] min_per =
		(spd_q == SPD_QUAD)		? MINP_QUAD :
		(spd_q == SPD_DOUBLE)	? MINP_DOUBLE : MINP_SINGLE;
	wire rate_evt	= ce & frm_rise & primed_q & (per_cnt_q < min_per);
	wire [CNT_W-1:0] per_inc = (&per_cnt_q) ? per_cnt_q : per_cnt_q + 1'b1;

	// status: new events win over a read clear
	wire [7:0] ev_w	= (8'(ovf_evt) << ST_OVF) | (8'(rate_evt) << ST_RATE);
	wire [7:0] clr_w = rd_istat ? 8'hFF : 8'h00;
	wire [7:0] status_d = (status_q & ~clr_w) | ev_w;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fmode_q <= FMODE_RST;
			misc_q <= MISC_RST;
			clksel_q <= ZERO_RST;
			gain_l_q <= ZERO_RST;
			gain_r_q <= ZERO_RST;
			mask_q <= ZERO_RST;
		end else begin
			if (wr_fmode) fmode_q <= reg_wdata;
			if (wr_misc) misc_q <= reg_wdata;
			if (wr_clk) clksel_q <= reg_wdata;
			if (wr_gain_l) gain_l_q <= reg_wdata;
			if (wr_gain_r) gain_r_q <= reg_wdata;
			if (wr_mask) mask_q <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_GPO; i++) gpo_reg_q[i] <= ZERO_RST;
		end else if (take_wr && gpo_hit) begin
			gpo_reg_q[gpo_idx] <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata_q <= 8'h00;
			status_q <= ZERO_RST;
			irq_q <= 1'b0;
		end else if (ce) begin
			reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
			status_q <= status_d;
			irq_q <= |(status_q & mask_q);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			spd_q <= SPD_SINGLE;
			osr_ratio_q <= OSR_SINGLE;
			sys_clk_sel_q <= 1'b0;
		end else if (ce) begin
			spd_q <= speed_of(fmode_q[1:0]);
			case (spd_q)
				SPD_QUAD: osr_ratio_q <= OSR_QUAD;
				SPD_DOUBLE: osr_ratio_q <= OSR_DOUBLE;
				default: osr_ratio_q <= OSR_SINGLE;
			endcase
			sys_clk_sel_q <= clksel_q[CLK_SEL];
		end
	end

	// general pins show the sticky overflow, a steady high or low, as their function code picks
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			general_output_pin_q <= '0;
		end else if (ce) begin
			for (int i = 0; i < NUM_GPO; i++)
				general_output_pin_q[i] <= gpo_level(gpo_reg_q[i][1:0], status_q[ST_OVF]);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			est_l_q <= '0;
			est_r_q <= '0;
		end else if (track) begin
			if (dec_right) est_r_q <= est_new;
			else est_l_q <= est_new;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			word_l_q <= '0;
			word_r_q <= '0;
		end else if (take) begin
			if (dec_right) word_r_q <= word_new;
			else word_l_q <= word_new;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			frm_s1_q <= 1'b0;
			frm_s2_q <= 1'b0;
			frm_s3_q <= 1'b0;
			bclk_s1_q <= 1'b0;
			bclk_s2_q <= 1'b0;
			bclk_s3_q <= 1'b0;
		end else if (ce) begin
			frm_s1_q <= adc_frame_clock;
			frm_s2_q <= frm_s1_q;
			frm_s3_q <= frm_s2_q;
			bclk_s1_q <= adc_bit_clock;
			bclk_s2_q <= bclk_s1_q;
			bclk_s3_q <= bclk_s2_q;
		end
	end

	// serial word loads on frame edges, shifts on bit clock falls
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			shift_q <= '0;
			adc_sdout_q <= 1'b0;
		end else if (ce) begin
			shift_q <= shift_d;
			adc_sdout_q <= shift_d[SLOT_W-1];
		end
	end

	// frame period measurement, saturating while the link clock stands
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			per_cnt_q <= '0;
			primed_q <= 1'b0;
		end else if (ce) begin
			per_cnt_q <= frm_rise ? CNT_W'(1) : per_inc;
			if (frm_rise) primed_q <= 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence clip_pos_s;
		take && clip && !neg;
	endsequence
	sequence clip_neg_s;
		take && clip && neg;
	endsequence
	sequence left_load_s;
		ce && frm_rise;
	endsequence
	sequence quad_held_s;
		(ce && fmode_q[1:0] == MODE_QUAD)[*2];
	endsequence

	sat_pos_a: assert property (clip_pos_s |=>
		($past(dec_right) ? word_r_q : word_l_q) == POS_FS)
		else $error("positive clamp value wrong");
	sat_neg_a: assert property (clip_neg_s |=>
		($past(dec_right) ? word_r_q : word_l_q) == NEG_FS)
		else $error("negative clamp value wrong");
	ovf_flag_a: assert property (clip_pos_s or clip_neg_s |=> status_q[ST_OVF])
		else $error("overflow flag not set on clamp");
	read_clear_a: assert property (rd_istat && !ovf_evt && !rate_evt |=> status_q == 8'h00)
		else $error("status not cleared by read");
	osr_quad_a: assert property (quad_held_s |=> osr_ratio_q == OSR_QUAD)
		else $error("quad speed ratio wrong");
	rate_flag_a: assert property (rate_evt |=> status_q[ST_RATE])
		else $error("frame rate flag not set");
	hold_est_a: assert property (take && hold |=> $stable(est_l_q) && $stable(est_r_q))
		else $error("estimate moved while held");
	track_est_a: assert property (track && !dec_right && step != 0
		|=> est_l_q != $past(est_l_q))
		else $error("estimate not updated");
	bypass_a: assert property (take && !subtract && gain == 2'h0 && !clip && !dec_right
		|=> word_l_q == $past(dec_data[OUT_W-1:0]))
		else $error("filter off word altered");
	gpo_ovf_a: assert property (ce && gpo_reg_q[0][1:0] == GPO_FN_OVF && status_q[ST_OVF]
		|=> general_output_pin_q[0])
		else $error("general pin misses overflow");
	left_slot_a: assert property (left_load_s |=> adc_sdout_q == $past(word_l_q[OUT_W-1]))
		else $error("left word not first after frame rise");
	irq_line_a: assert property (ce && |(status_q & mask_q) |=> irq_q)
		else $error("interrupt not raised");
endmodule : aof_filter

// ---- tb/aof_rx_model.sv ----
// aof_rx_model: serial audio receiver that clocks frames and captures the data line
module aof_rx_model (
	output	logic			adc_frame_clock,
	output	logic			adc_bit_clock,
	input	wire logic		sdout,
	output	logic [71:0]	cap_word,
	output	logic			cap_stb
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		adc_frame_clock = 1'b0;
		adc_bit_clock = 1'b0;
		cap_word = '0;
		cap_stb = 1'b0;
	end

	// bit clock runs only inside a frame and rests low between frames
	task automatic frame(input logic side, input int nbits, input int half_ns);
		cap_word = '0;
		adc_frame_clock = side;
		for (int i = 0; i < nbits; i++) begin
			#32 adc_bit_clock = 1'b1;
			cap_word = {cap_word[70:0], sdout};
			#32 adc_bit_clock = 1'b0;
		end
		#(half_ns - 64 * nbits);
		cap_stb = 1'b1;
		#5 cap_stb = 1'b0;
	endtask : frame
endmodule : aof_rx_model

// ---- tb/aof_filter_test.sv ----
// aof_filter_test: self-checking bench for the adc back end with a receiver model
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %s expected %h seen %h", n, e, g); end end
module aof_filter_test;
	timeunit 1ns;
	timeprecision 100ps;
	import aof_pkg::*;

	logic				mclk, rst, ce, reg_wr, reg_rd, dec_valid, dec_right;
	logic [7:0]			reg_addr, reg_wdata, reg_rdata_q, osr_ratio_q;
	logic [27:0]		dec_data;
	logic [23:0]		e1l, e1r, e2l, e2r;
	logic [6:0]			pins;
	logic				frm, bclk, sdout, sys_sel, irq, cap_stb, rd_d, flt, hold, ol;
	logic [71:0]		cap_word, exp_r, exp_s;
	logic [71:0]		q[$];
	logic signed [35:0]	est[2];
	logic [23:0]		res[2];
	int					gn[2];
	int					errors, samples_checked;
	logic [31:0]		rv;

	aof_filter DUT (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .dec_valid(dec_valid), .dec_right(dec_right),
		.dec_data(dec_data), .ext1_left(e1l), .ext1_right(e1r), .ext2_left(e2l),
		.ext2_right(e2r), .adc_frame_clock(frm), .adc_bit_clock(bclk),
		.reg_rdata_q(reg_rdata_q), .adc_sdout_q(sdout), .osr_ratio_q(osr_ratio_q),
		.sys_clk_sel_q(sys_sel), .general_output_pin_q(pins), .irq_q(irq));
	aof_rx_model rx (.adc_frame_clock(frm), .adc_bit_clock(bclk), .sdout(sdout),
		.cap_word(cap_word), .cap_stb(cap_stb));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	function automatic logic [23:0] sat(input logic signed [35:0] v);
		if (v > 36'sh0_007F_FFFF)
			return POS_FS;
		if (v < -36'sh0_0080_0000)
			return NEG_FS;
		return v[23:0];
	endfunction : sat

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == REG_MISC)
			{ol, flt, hold} = d[2:0];
		if (a == REG_GAIN_L || a == REG_GAIN_R)
			gn[a[0]] = int'(d[1:0]);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back({64'h0, e});
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask : rd

	// expected word uses the estimate from before this sample
	task automatic smp(input logic r, input logic [27:0] d);
		logic signed [35:0] v;
		v = 36'(signed'(d));
		if (flt || hold)
			v = v - est[r];
		if (flt && !hold)
			est[r] = est[r] + ((36'(signed'(d)) - est[r]) >>> HPF_SHIFT);
		res[r] = sat(v <<< gn[r]);
		@(posedge mclk);
		dec_valid <= 1'b1;
		dec_right <= r;
		dec_data <= d;
		@(posedge mclk);
		dec_valid <= 1'b0;
	endtask : smp

	task automatic pair(input int half);
		q.push_back(ol ? {res[0], e1l, e2l} : {48'h0, res[0]});
		rx.frame(1'b1, ol ? 72 : 24, half);
		q.push_back(ol ? {res[1], e1r, e2r} : {48'h0, res[1]});
		rx.frame(1'b0, ol ? 72 : 24, half);
	endtask : pair

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle

	task automatic conclude();
		if (q.size() != 0)
			errors++;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	always @(posedge mclk) begin
		if (rd_d) begin
			exp_r = q.pop_front();
			`CHK("rdata", exp_r[7:0], reg_rdata_q)
		end
		rd_d <= reg_rd;
	end

	always @(posedge cap_stb) begin
		exp_s = q.pop_front();
		`CHK("serial", exp_s, cap_word)
	end

	initial begin
		repeat (90000) @(posedge mclk);
		errors++;
		conclude();
	end

	initial begin
		void'($urandom(32'h6d42_db8e));
		{rst, ce, reg_wr, reg_rd, dec_valid, dec_right} = 6'b11_0000;
		reg_addr = '0;
		reg_wdata = '0;
		dec_data = '0;
		{e1l, e1r, e2l, e2r} = {$urandom, $urandom, $urandom};
		{ol, flt, hold} = 3'b010;
		est = '{36'sh0, 36'sh0};
		gn = '{0, 0};
		rd_d = 1'b0;
		errors = 0;
		samples_checked = 0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rd(REG_FMODE, FMODE_RST);	// speed default
		rd(REG_MISC, MISC_RST);	// misc default
		rd(REG_ISTAT, ZERO_RST);	// status starts clear
		rd(8'h7E, 8'h00);	// unmapped read
		`CHK("clksel", 1'b0, sys_sel) // recovered clock after reset
		for (int i = 0; i < 4; i++) begin
			wr(REG_FMODE, 8'(i));
			settle(3);
			`CHK("osr", (i == 1) ? OSR_DOUBLE : (i == 2) ? OSR_QUAD : OSR_SINGLE, osr_ratio_q) // ratio
		end
		wr(REG_CLK, 8'h01);
		settle(3);
		`CHK("clksel", 1'b1, sys_sel) // reference clock chosen
		@(posedge mclk);
		ce <= 1'b0;
		wr(REG_CLK, 8'h00);
		ce <= 1'b1;
		rd(REG_CLK, 8'h01);	// write ignored while frozen
		// raw words, then both rails
		wr(REG_MISC, 8'h00);	// filter off
		wr(REG_GPO_LO, {6'h00, GPO_FN_OVF});
		wr(REG_GPO_LO + 8'h01, {6'h00, GPO_FN_HIGH});
		rv = $urandom;
		smp(1'b0, {{5{rv[22]}}, rv[22:0]});
		rv = $urandom;
		smp(1'b1, {{5{rv[22]}}, rv[22:0]});
		pair(10500);	// raw two's complement words
		rd(REG_ISTAT, 8'h00);	// no clamp no flag
		smp(1'b0, 28'h7FF_FFFF);
		smp(1'b1, 28'h800_0000);
		settle(4);
		`CHK("irq", 1'b0, irq) // masked event
		`CHK("pins", 2'b11, pins[1:0]) // pin shows overflow
		wr(REG_IMASK, 8'h01);
		settle(3);
		`CHK("irq", 1'b1, irq) // unmasked event
		pair(10500);	// both rails
		rd(REG_ISTAT, 8'h01);	// overflow flag
		rd(REG_ISTAT, 8'h00);	// read clears
		settle(3);
		`CHK("irq", 1'b0, irq) // cleared
		`CHK("pins", 2'b10, pins[1:0]) // pin follows flag
		wr(REG_GAIN_L, 8'h01);
		smp(1'b0, 28'h040_0000);
		smp(1'b1, 28'h040_0000);
		pair(10500);	// clamp judged after gain
		rd(REG_ISTAT, 8'h01);	// flag judged after gain
		wr(REG_GAIN_L, 8'h00);
		wr(REG_MISC, 8'h02);
		for (int i = 0; i < 3; i++) begin
			smp(1'b0, 28'h010_0000);
			smp(1'b1, 28'hFF0_0000);
			pair(10500);	// offset tracked per channel
		end
		wr(REG_MISC, 8'h03);
		smp(1'b0, 28'h010_0000);
		smp(1'b1, 28'hFF0_0000);
		pair(10500);	// estimate frozen
		wr(REG_MISC, 8'h01);	// filter off, offset kept
		rv = $urandom;
		smp(1'b0, {{5{rv[22]}}, rv[22:0]});
		smp(1'b1, 28'h020_0000);
		pair(10500);	// held offset still subtracted
		wr(REG_MISC, 8'h04);
		smp(1'b0, 28'h000_1234);
		smp(1'b1, 28'hFFF_EDCC);
		pair(10500);	// three words on one line
		wr(REG_MISC, 8'h00);
		wr(REG_FMODE, {6'h00, MODE_QUAD});
		pair(3000);
		pair(3000);
		rd(REG_ISTAT, 8'h00);	// fast frames accepted
		wr(REG_FMODE, 8'h00);
		pair(3000);
		pair(3000);
		settle(2);
		`CHK("irq", 1'b0, irq) // rate bit masked
		rd(REG_ISTAT, 8'h02);	// too fast for single rate
		settle(2);
		conclude();
	end
endmodule : aof_filter_test
